// ==== verilog/brbs_pkg.sv ====
// Package of opcodes, field positions and timing constants for brbs_exec
package brbs_pkg;
	// Quarter-phase codes within one instruction cycle
	localparam logic [1:0] BRBS_Q1 = 2'h0;
	localparam logic [1:0] BRBS_Q2 = 2'h1;
	localparam logic [1:0] BRBS_Q3 = 2'h2;
	localparam logic [1:0] BRBS_Q4 = 2'h3;

	// Opcode match patterns
	localparam logic [7:0] BRBS_OP_IF_NONZERO = 8'hE1;  // Upper byte, nonzero branch
	localparam logic [4:0] BRBS_OP_ALWAYS     = 5'h1A;  // 1101_0 prefix
	localparam logic [3:0] BRBS_OP_SET_BIT    = 4'h8;   // 1000 prefix

	// Field positions in the instruction word
	localparam int BRBS_BIT_LSB   = 9;   // b field, bits 11:9
	localparam int BRBS_A_POS     = 8;   // access-select bit
	localparam int BRBS_LONG_MSB  = 10;  // 11-bit offset sign bit
	localparam int BRBS_SHORT_MSB = 7;   // 8-bit offset sign bit

	// Highest register operand that uses indexed literal offset
	localparam logic [7:0] BRBS_ILO_MAX  = 8'h5F;
	// Upper nibble of the access bank's special register half
	localparam logic [3:0] BRBS_SFR_BANK = 4'hF;

	// Reset values
	localparam logic [15:0] BRBS_IR_RST  = 16'h0000;  // No-operation word
endpackage

// ==== verilog/brbs_exec.sv ====
// Decode and execute of nonzero branch, unconditional branch and bit set
// Summary of operation
// - Opcode E1nn branches on signed n only when zero flag is clear.
// - Taken branch target is incremented fetch address plus twice the offset.
// - Conditional branch is one word; one cycle untaken, two when taken.
// - Q1 decode, Q2 offset, Q3 process, Q4 PC write, then a NOP cycle.
// - Prefix 1101_0 with 11-bit offset always branches, two cycles, no flags.
// - Bit set with a=0 and extended set uses indexed offset when f<=95.
`timescale 1ns/1ps
`default_nettype none
module brbs_exec #(
	parameter int PC_W = 21,   // Program counter width
	parameter int DA_W = 12    // Data memory address width
) (
	input  wire logic            clk_i,          // Core clock, 50 MHz
	input  wire logic            rst_n_i,        // Synchronous reset, active low
	input  wire logic [15:0]     instr_i,        // Fetched word, taken in Q1
	input  wire logic [PC_W-1:0] pc_i,           // Already incremented PC
	input  wire logic            zero_flag_i,    // Status zero flag
	input  wire logic            ext_set_en_i,   // Extended instruction set on
	input  wire logic [3:0]      bank_sel_reg_i, // Bank select register
	input  wire logic [DA_W-1:0] fsr2_i,         // Index base for literal offset
	input  wire logic [7:0]      mem_rdata_i,    // Data memory read data
	output logic      [1:0]      phase_o,        // Current quarter phase
	output logic                 pc_load_o,      // Load PC in Q4
	output logic      [PC_W-1:0] pc_target_o,    // Branch destination
	output logic                 nop_cycle_o,    // Forced no-operation cycle
	output logic      [DA_W-1:0] mem_addr_o,     // Data memory address
	output logic                 mem_rd_o,       // Read strobe in Q3
	output logic                 mem_wr_o,       // Write strobe in Q4
	output logic      [7:0]      mem_wdata_o     // Write data
);
	import brbs_pkg::*;

	typedef enum logic [1:0] {
		BRBS_EXEC  = 2'b01,
		BRBS_FLUSH = 2'b10
	} brbs_state_t;

	brbs_state_t       state;
	logic [15:0]       ir;
	logic [PC_W-1:0]   next_target;
	logic [DA_W-1:0]   next_addr;
	logic [7:0]        next_wdata;
	logic              next_taken;

	// Decoders shared by the datapath and the checks
	function automatic logic is_nonzero_br(input logic [15:0] w);
		return w[15:8] == BRBS_OP_IF_NONZERO;
	endfunction

	function automatic logic is_always_br(input logic [15:0] w);
		return w[15:11] == BRBS_OP_ALWAYS;
	endfunction

	function automatic logic is_set_bit(input logic [15:0] w);
		return w[15:12] == BRBS_OP_SET_BIT;
	endfunction

	// Sign-extended displacement, already doubled
	function automatic logic [PC_W-1:0] branch_disp(input logic [15:0] w);
		logic [PC_W-1:0] d;
		if (is_always_br(w)) begin
			d = {{(PC_W-11){w[BRBS_LONG_MSB]}}, w[10:0]};
		end else begin
			d = {{(PC_W-8){w[BRBS_SHORT_MSB]}}, w[7:0]};
		end
		return {d[PC_W-2:0], 1'b0};
	endfunction

	// Quarter-phase counter runs free; four clocks per instruction cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			phase_o <= BRBS_Q1;
		end else begin
			phase_o <= phase_o + 2'h1;
		end
	end

	// Q1 decode; a flush cycle loads a no-operation word instead
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ir <= BRBS_IR_RST;
		end else if (phase_o == BRBS_Q1) begin
			ir <= (state == BRBS_FLUSH) ? BRBS_IR_RST : instr_i;
		end
	end

	// Branch condition and destination
	always_comb begin
		// An unconditional branch ignores the zero flag entirely
		next_taken  = is_always_br(ir)
			|| (is_nonzero_br(ir) && !zero_flag_i);
		next_target = pc_i + branch_disp(ir);
	end

	// Q3 process ends in a Q4 PC write for a taken branch only
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pc_load_o   <= 1'b0;
			pc_target_o <= '0;
		end else if (phase_o == BRBS_Q3) begin
			pc_load_o   <= next_taken;
			pc_target_o <= next_target;
		end else begin
			pc_load_o   <= 1'b0;
		end
	end

	// Taken branch costs a whole extra cycle; untaken one does not
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state       <= BRBS_EXEC;
			nop_cycle_o <= 1'b0;
		end else if (phase_o == BRBS_Q4) begin
			case (state)
				BRBS_EXEC: begin
					if (pc_load_o) begin
						state       <= BRBS_FLUSH;
						nop_cycle_o <= 1'b1;
					end
				end
				BRBS_FLUSH: begin
					state       <= BRBS_EXEC;
					nop_cycle_o <= 1'b0;
				end
				default: begin
					state       <= BRBS_EXEC;
					nop_cycle_o <= 1'b0;
				end
			endcase
		end
	end

	// Register operand address; the index window only below the SFR half
	always_comb begin
		if (ir[BRBS_A_POS]) begin
			next_addr = {bank_sel_reg_i, ir[7:0]};
		end else if (ext_set_en_i && ir[7:0] <= BRBS_ILO_MAX) begin
			next_addr = fsr2_i + {{(DA_W-8){1'b0}}, ir[7:0]};
		end else if (ir[7:0] <= BRBS_ILO_MAX) begin
			next_addr = {{(DA_W-8){1'b0}}, ir[7:0]};
		end else begin
			next_addr = {BRBS_SFR_BANK, ir[7:0]};
		end
		next_wdata = mem_rdata_i | (8'h01 << ir[11:9]);
	end

	// Read in Q3, write back in Q4 of the same cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mem_addr_o  <= '0;
			mem_rd_o    <= 1'b0;
			mem_wr_o    <= 1'b0;
			mem_wdata_o <= 8'h00;
		end else begin
			mem_rd_o <= (phase_o == BRBS_Q2) && is_set_bit(ir);
			mem_wr_o <= (phase_o == BRBS_Q3) && is_set_bit(ir);
			if (phase_o == BRBS_Q2) begin
				mem_addr_o <= next_addr;
			end
			if (phase_o == BRBS_Q3) begin
				mem_wdata_o <= next_wdata;
			end
		end
	end

	// Checks; targets are rebuilt from the fetched word, not the datapath
	chk_phase_wrap: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		phase_o == BRBS_Q4 |=> phase_o == BRBS_Q1)
		else $error("phase did not wrap");
	chk_nonzero_taken: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		phase_o == BRBS_Q3 && is_nonzero_br(ir)
		|=> pc_load_o == !$past(zero_flag_i))
		else $error("nonzero branch decision wrong");
	chk_nonzero_target: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		phase_o == BRBS_Q3 && is_nonzero_br(ir) && !zero_flag_i
		|=> pc_target_o == $past(pc_i)
		+ {{(PC_W-9){$past(ir[BRBS_SHORT_MSB])}}, $past(ir[7:0]), 1'b0})
		else $error("nonzero branch target wrong");
	chk_always_target: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		phase_o == BRBS_Q3 && is_always_br(ir)
		|=> pc_load_o && pc_target_o == $past(pc_i)
		+ {{(PC_W-12){$past(ir[BRBS_LONG_MSB])}}, $past(ir[10:0]), 1'b0})
		else $error("unconditional branch target wrong");
	chk_refused_quiet: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		phase_o == BRBS_Q3 && !is_nonzero_br(ir) && !is_always_br(ir)
		|=> !pc_load_o)
		else $error("PC loaded by a non-branch word");
	chk_taken_flush: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		pc_load_o |=> nop_cycle_o [*4] ##1 !nop_cycle_o)
		else $error("taken branch not followed by one nop cycle");
	chk_flush_quiet: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		nop_cycle_o |-> !pc_load_o && !mem_rd_o && !mem_wr_o)
		else $error("strobe raised during nop cycle");
	chk_untaken_one: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		phase_o == BRBS_Q4 && !pc_load_o && !nop_cycle_o
		|=> !nop_cycle_o)
		else $error("untaken branch stalled");
	chk_load_in_q4: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		pc_load_o |-> phase_o == BRBS_Q4 && !nop_cycle_o)
		else $error("PC loaded outside Q4");
	chk_ilo_addr: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		phase_o == BRBS_Q2 && is_set_bit(ir) && !ir[BRBS_A_POS]
		&& ext_set_en_i && ir[7:0] <= BRBS_ILO_MAX
		|=> mem_rd_o && mem_addr_o
		== $past(fsr2_i) + {{(DA_W-8){1'b0}}, $past(ir[7:0])})
		else $error("indexed offset address wrong");
	chk_bank_addr: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		phase_o == BRBS_Q2 && is_set_bit(ir) && ir[BRBS_A_POS]
		|=> mem_addr_o == {$past(bank_sel_reg_i), $past(ir[7:0])})
		else $error("banked address wrong");
	chk_set_bit_write: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		mem_rd_o |=> mem_wr_o && mem_wdata_o[$past(ir[11:9])]
		&& (mem_wdata_o | (8'h01 << $past(ir[11:9])))
		== ($past(mem_rdata_i) | (8'h01 << $past(ir[11:9]))))
		else $error("bit set write wrong");
endmodule
`default_nettype wire

// ==== testbench/tb_brbs_exec.sv ====
// Self-checking bench for the branch and bit set decoder
`timescale 1ns/1ps
`default_nettype none
module tb_brbs_exec;
	import brbs_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [15:0] instr_i = 16'h0000;
	logic [20:0] pc_i = 21'h000300;
	logic        zero_flag_i = 1'b0;
	logic        ext_set_en_i = 1'b0;
	logic [3:0]  bank_sel_reg_i = 4'h5;
	logic [11:0] fsr2_i = 12'h123;
	logic [7:0]  mem_rdata_i = 8'h24;
	logic [1:0]  phase_o;
	logic        pc_load_o, nop_cycle_o, mem_rd_o, mem_wr_o;
	logic [20:0] pc_target_o, tg;
	logic [11:0] mem_addr_o, ad;
	logic [7:0]  mem_wdata_o, wd;
	int          fails = 0;
	int          checked = 0;
	int          ld, rd, wr, nop;
	brbs_exec brbs_exec_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.instr_i(instr_i), .pc_i(pc_i), .zero_flag_i(zero_flag_i),
		.ext_set_en_i(ext_set_en_i), .bank_sel_reg_i(bank_sel_reg_i),
		.fsr2_i(fsr2_i), .mem_rdata_i(mem_rdata_i), .phase_o(phase_o),
		.pc_load_o(pc_load_o), .pc_target_o(pc_target_o),
		.nop_cycle_o(nop_cycle_o), .mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o));
	// 50 MHz core clock
	always #10 clk_i = ~clk_i;
	task end_sim;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [20:0] got, input logic [20:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// A strobe off its own phase weighs 10, so a stray pulse shows
	function automatic int hit(input logic s, input int k, input int at);
		return (s === 1'b1) ? ((k == at) ? 1 : 10) : 0;
	endfunction
	// One word through Q1..Q4 plus the following cycle; a no-op word
	// replaces it after decode so an untaken branch is not run twice
	task run(input logic [15:0] w);
		// Right after an edge the phase still shows its old value
		@(negedge clk_i);
		while (phase_o !== 2'h3) @(negedge clk_i);
		@(posedge clk_i) instr_i <= w;
		@(posedge clk_i);
		@(posedge clk_i) instr_i <= 16'h0000;
		{ld, rd, wr, nop} = '0;
		for (int k = 0; k < 6; k++) begin
			@(negedge clk_i);
			rd += hit(mem_rd_o, k, 0);
			ld += hit(pc_load_o, k, 1);
			wr += hit(mem_wr_o, k, 1);
			nop += (nop_cycle_o === 1'b1) ? ((k > 1) ? 1 : 10) : 0;
			if (k == 1) {tg, ad, wd} = {pc_target_o, mem_addr_o, mem_wdata_o};
		end
	endtask
	task br(input logic [15:0] w, input logic z, input logic [10:0] n,
		input logic tk);
		@(posedge clk_i) zero_flag_i <= z;
		run(w);
		chk(21'(ld), 21'(tk));
		chk(21'(nop), tk ? 21'h000004 : 21'h000000);
		chk(21'(rd + wr), 21'h000000);
		if (tk) chk(tg, pc_i + {{9{n[10]}}, n, 1'b0});
	endtask
	task bs(input logic [2:0] b, input logic a, input logic [7:0] f,
		input logic ext, input logic [11:0] ea);
		@(posedge clk_i) ext_set_en_i <= ext;
		run({4'h8, b, a, f});
		chk(21'(ld + nop), 21'h000000);
		chk(21'(rd * 16 + wr), 21'h000011);
		chk(21'(ad), 21'(ea));
		chk(21'(wd), 21'(8'h24 | (8'h01 << b)));
	endtask
	task t_nonzero;
		br(16'hE180, 1'b0, 11'h780, 1'b1);
		br(16'hE17F, 1'b1, 11'h07F, 1'b0);
		br(16'hE17F, 1'b0, 11'h07F, 1'b1);
	endtask
	task t_always;
		br(16'hD400, 1'b1, 11'h400, 1'b1);
		br(16'hD3FF, 1'b0, 11'h3FF, 1'b1);
	endtask
	// Near-miss opcodes must leave every strobe low
	task t_refuse;
		br(16'hE000, 1'b0, 11'h000, 1'b0);
		br(16'hD800, 1'b0, 11'h000, 1'b0);
	endtask
	task t_set_bit;
		for (int i = 0; i < 8; i++) bs(3'(i), 1'b1, 8'hC3, 1'b0, 12'h5C3);
		bs(3'd2, 1'b0, 8'h5F, 1'b1, 12'h182);
		bs(3'd7, 1'b0, 8'h60, 1'b1, 12'hF60);
		bs(3'd0, 1'b0, 8'h10, 1'b0, 12'h010);
	endtask
	// Whole run is well under 1000 cycles
	initial begin
		#100000;
		fails++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim;
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_nonzero;
		t_always;
		t_refuse;
		t_set_bit;
		end_sim;
	end
endmodule
`default_nettype wire
